/* File: verification/pah_cmd_asserts.sv */
// Port-level checks of the power and address command handler.
`timescale 1ns/10ps
module pah_cmd_asserts (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire pah_pkg::pah_wake_src_type wake_src,
  input wire logic rsp_valid_ff,
  input wire logic low_power_ff,
  input wire logic [7:0] lp_mode_ff,
  input wire logic radio_standby_ff,
  input wire logic wake_pulse_ff,
  input wire logic net_reset_ff,
  input wire logic [15:0] pan_id_ff,
  input wire logic [63:0] long_addr_ff,
  input wire logic [7:0] wake_per_ff
);
  import pah_pkg::*;
  // One clock domain, so clocking and reset masking are shared.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_rsp; rsp_valid_ff |=> !rsp_valid_ff; endproperty
  a_rsp: assert property (p_rsp) else $error("response strobe too long");
  property p_nrst; net_reset_ff |=> !net_reset_ff; endproperty
  a_nrst: assert property (p_nrst) else $error("network reset too long");
  property p_wake; wake_pulse_ff == $fell(low_power_ff); endproperty
  a_wake: assert property (p_wake) else $error("wake pulse not tied to exit");
  property p_id; pan_id_ff != ID_INVALID; endproperty
  a_id: assert property (p_id) else $error("invalid identifier stored");
  property p_addr; long_addr_ff != '0 && long_addr_ff != '1; endproperty
  a_addr: assert property (p_addr) else $error("invalid long address stored");
  property p_res; wake_per_ff[7:6] == 2'b00; endproperty
  a_res: assert property (p_res) else $error("reserved source bits stored");
  property p_rdo; radio_standby_ff |-> low_power_ff; endproperty
  a_rdo: assert property (p_rdo) else $error("radio standby while awake");
  // A rising edge on the dedicated pin must end standby promptly when enabled.
  property p_pin; low_power_ff && lp_mode_ff == MODE_STANDBY && wake_per_ff[PER_WAKE_PIN] &&
    $rose(wake_src.wake_pin) |-> ##[1:2] !low_power_ff; endproperty
  a_pin: assert property (p_pin) else $error("wake pin ignored in standby");
endmodule : pah_cmd_asserts

bind pah_cmd_handler pah_cmd_asserts u_chk (.ref_clk, .arst_n, .wake_src, .rsp_valid_ff, .low_power_ff,
  .lp_mode_ff, .radio_standby_ff, .wake_pulse_ff, .net_reset_ff, .pan_id_ff, .long_addr_ff, .wake_per_ff);

/* File: verification/pah_cmd_handler_tb.sv */
// Self-checking bench of the power and address command handler.
`timescale 1ns/10ps
module pah_cmd_handler_tb;
  import pah_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  pah_bus_req_type bus_req = '0;
  pah_frame_type frm;
  pah_wake_src_type wake_src = '0;
  logic [0:0][127:0] net_addr = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  logic [31:0] bus_rdata_ff, wake_fall_ff, wake_rise_ff;
  pah_rsp_type rsp_ff;
  logic rsp_valid_ff, tx_valid_ff, tx_last_ff, low_power_ff, radio_standby_ff, wake_pulse_ff, net_reset_ff;
  logic [7:0] tx_byte_ff, lp_mode_ff, wake_per_ff;
  logic [15:0] tx_len_ff, pan_id_ff;
  logic [63:0] long_addr_ff;
  int miscompares = 0;
  int total_checks = 0;
  int rsp_cnt = 0;
  int nrst_cnt = 0;
  // A short second keeps timer waits to a few cycles.
  pah_cmd_handler #(.CYC_PER_SEC(10)) u_dut (.ref_clk, .arst_n, .bus_req, .bus_rdata_ff, .frm, .net_addr,
    .wake_src, .rsp_ff, .rsp_valid_ff, .tx_valid_ff, .tx_byte_ff, .tx_last_ff, .tx_len_ff, .low_power_ff,
    .lp_mode_ff, .radio_standby_ff, .wake_pulse_ff, .net_reset_ff, .pan_id_ff, .long_addr_ff, .wake_per_ff,
    .wake_fall_ff, .wake_rise_ff);
  pah_host_model u_host (.ref_clk, .frm);
  always #25 ref_clk = ~ref_clk;
  // Pulse counters let silent outcomes be judged.
  always @(posedge ref_clk) begin
    rsp_cnt += rsp_valid_ff;
    nrst_cnt += net_reset_ff;
  end
  task automatic chk(input logic [199:0] s, e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %0t seen %0h expected %0h", $time, s, e);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // Bounded wait; running out ends the run as a failure.
  task automatic wait_for(ref logic f, input logic v, input int n);
    for (int i = 0; i < n && f !== v; i++) @(negedge ref_clk);
    if (f !== v) begin
      miscompares++;
      print_verdict();
    end
  endtask : wait_for
  task automatic bw(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask : bw
  task automatic br(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req <= '0;
    @(negedge ref_clk);
    chk(bus_rdata_ff, e);
  endtask : br
  task automatic cmd(input logic [7:0] op, input logic [7:0] b[$], input logic [7:0] c);
    u_host.send(op, b);
    wait_for(rsp_valid_ff, 1'b1, 20);
    chk(rsp_ff.code, c);
  endtask : cmd
  task automatic wcfg(input logic [7:0] p, input logic [31:0] f, r, input logic [7:0] c);
    cmd(OP_WAKE_CFG, '{p, f[31:24], f[23:16], f[15:8], f[7:0], r[31:24], r[23:16], r[15:8], r[7:0]}, c);
  endtask : wcfg
  task automatic t_id();
    chk({pan_id_ff, long_addr_ff}, {RST_PAN_ID, RST_LONG_ADDR});
    br(4'hC, 32'h0000_0000);
    cmd(OP_SET_ID, '{8'h12, 8'h34}, RSP_OK);
    cmd(OP_SET_ID, '{8'hFF, 8'hFF}, RSP_BAD_VALUE);
    cmd(OP_SET_ID, '{8'h56}, RSP_SHORT);
    cmd(OP_SET_ID, '{8'h56, 8'h78, 8'h9A}, RSP_LONG);
    br(REG_PAN_ID, 32'h0000_1234);
    bw(REG_CTRL, 32'h0000_0000);
    u_host.send(OP_SET_ID, '{8'h56, 8'h78});
    repeat (4) @(negedge ref_clk);
    chk({rsp_cnt, pan_id_ff}, {32'd4, 16'h5678});
    bw(REG_CTRL, 32'h0000_0001);
  endtask : t_id
  task automatic t_long();
    logic [199:0] got;
    got = '0;
    cmd(OP_SET_LONG, '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h01}, RSP_OK);
    cmd(OP_SET_LONG, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, RSP_BAD_ADDR);
    chk({nrst_cnt, long_addr_ff}, {32'd1, 64'h0102_0304_0506_0708});
    u_host.send(OP_GET_ADDR, '{8'hAA});
    for (int i = 0; i < 40 && tx_last_ff !== 1'b1; i++) begin
      @(negedge ref_clk);
      if (tx_valid_ff === 1'b1) got = {got[191:0], tx_byte_ff};
    end
    chk(got, {8'h00, 64'h0102_0304_0506_0708, net_addr[0]});
    chk(tx_len_ff, 16'd25);
  endtask : t_long
  task automatic t_wake();
    cmd(OP_WAKE_CFG, '{8'h01, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00}, RSP_OK);
    chk({wake_fall_ff, wake_rise_ff}, {32'h0000_0002, 32'h0000_0000});
    wcfg(8'h01, 32'h0000_0001, 32'h0000_0000, RSP_NOT_GPIO);
    chk(rsp_ff.pin, 8'h00);
    bw(REG_GPIO_OUT, 32'h0000_0004);
    wcfg(8'h01, 32'h0000_0004, 32'h0000_0000, RSP_IS_OUTPUT);
    chk(rsp_ff.pin, 8'h02);
    bw(REG_GPIO_OUT, 32'h0000_0000);
    wcfg(8'h01, 32'h0000_0000, 32'h0080_0002, RSP_CONFLICT);
    chk(rsp_ff.pin, 8'h17);
    br(REG_WAKE_FALL, 32'h0000_0002);
    cmd(OP_WAKE_CFG, '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, RSP_SHORT);
    wcfg(8'hC1, 32'h0000_0000, 32'h0000_0000, RSP_OK);
    chk(wake_per_ff, 8'h01);
  endtask : t_wake
  task automatic t_power();
    logic [7:0] m[3] = '{MODE_SLEEP, MODE_STOP, MODE_STANDBY};
    cmd(OP_POWER_DOWN, '{8'h05, 8'h00, 8'h00, 8'h00, 8'h00}, RSP_BAD_VALUE);
    foreach (m[i]) begin
      cmd(OP_POWER_DOWN, '{m[i], 8'h00, 8'h00, 8'h00, 8'h01}, RSP_OK);
      chk({low_power_ff, lp_mode_ff, radio_standby_ff}, {1'b1, m[i], 1'b1});
      repeat (5) @(negedge ref_clk);
      chk(low_power_ff, 1'b1);
      wait_for(low_power_ff, 1'b0, 20);
    end
    wcfg(8'h04, 32'h0000_0000, 32'h0000_0000, RSP_OK);
    cmd(OP_POWER_DOWN, '{MODE_STANDBY, 8'h00, 8'h00, 8'h00, 8'h00}, RSP_OK);
    @(posedge ref_clk);
    wake_src <= {5'b10111, 32'hFFFF_FFFF};
    repeat (20) @(negedge ref_clk);
    chk(low_power_ff, 1'b1);
    @(posedge ref_clk);
    wake_src <= '1;
    wait_for(low_power_ff, 1'b0, 4);
    @(posedge ref_clk);
    wake_src <= '0;
  endtask : t_power
  // Reset for eight cycles, then run each scenario in turn.
  initial begin
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(negedge ref_clk);
    t_id();
    t_long();
    t_wake();
    t_power();
    print_verdict();
  end
endmodule : pah_cmd_handler_tb

/* File: verification/pah_host_model.sv */
// Host model that sends command frames to the handler.
`timescale 1ns/10ps
module pah_host_model (
  input wire logic ref_clk,
  output pah_pkg::pah_frame_type frm
);
  import pah_pkg::*;
  initial frm = '0;
  // Start with opcode, bytes MSB first, then done; data is inverted on done, then inverted back to the last byte when released.
  task automatic send(input logic [7:0] op, input logic [7:0] b[$]);
    @(posedge ref_clk);
    frm <= '{start: 1'b1, op: op, default: '0};
    foreach (b[i]) begin
      @(posedge ref_clk);
      frm <= '{valid: 1'b1, data: b[i], op: ~op, default: '0};
    end
    @(posedge ref_clk);
    frm <= '{done: 1'b1, data: ~frm.data, default: '0};
    @(posedge ref_clk);
    frm <= '{data: ~frm.data, default: '0};
  endtask : send
endmodule : pah_host_model

/* File: verilog/pah_cmd_handler.sv */
// Command handler for wakeup setup, power-down, address readback and network addressing.
// Behaviour
// R1 - Wakeup: peripheral byte, 4-byte falling mask, 4-byte rising mask.
// R2 - 3-byte edge masks accepted; upper pins then cannot wake.
// R3 - Peripheral bit 0 enables timer wakeup; bits 7, 6 reserved.
// R4 - Bit 1 keeps radio receiving for wakeup; clear puts it in standby.
// R5 - Bit 2 enables wake pin 8, rising edge only; the code acts on the pin in standby mode only, not in sleep or stop.
// R6 - Bits 3, 4, 5 enable serial one, serial two, SPI wakeup.
// R7 - Short frame answers 1, long 2; success 0 only with acknowledges on.
// R8 - Non-GPIO pin selected answers 8 with its number.
// R9 - Output pin selected answers 9 with its number.
// R10 - Conflicting pins answer 12 with the conflicting pin number.
// R11 - Mode 0 sleep, 2 stop, 4 standby; else code 3.
// R12 - Duration in seconds applies only with the timer as wake source.
// R13 - Low power ends only on events of the last wakeup setup.
// R14 - Readback has no fields, ignores extras; length 9 plus 16 per address.
// R15 - Readback sends 8-byte identifier, then 16-byte addresses, MSB first.
// R16 - Long address: 8 bytes, optional flag; nonzero flag resets network.
// R17 - Unacceptable long address answers 19.
// R18 - Identifier takes two bytes, applies at once, no network reset.
// R19 - Identifier 0xFFFF is invalid, answers 3.
// R20 - Queued packets may leave with the new identifier.
// R21 - Standby wakes only on timer or wake pin.
// R22 - Stop wakes on GPIOs, radio or timer, not serial activity.
// R23 - Rejected command changes no setting; first error only answers.
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/10ps

module pah_cmd_handler #(
  parameter int unsigned CYC_PER_SEC = pah_pkg::CYC_PER_SEC,
  parameter int unsigned NADDR = 1,
  parameter logic [31:0] GPIO_PINS = pah_pkg::GPIO_PINS_DEF,
  parameter int unsigned NPAIR = 4,
  parameter logic [NPAIR*10-1:0] CONFLICT_PAIRS = pah_pkg::CONFLICT_DEF
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire pah_pkg::pah_bus_req_type bus_req,
  output logic [31:0] bus_rdata_ff,
  input wire pah_pkg::pah_frame_type frm,
  input wire logic [NADDR-1:0][127:0] net_addr,
  input wire pah_pkg::pah_wake_src_type wake_src,
  output pah_pkg::pah_rsp_type rsp_ff,
  output logic rsp_valid_ff,
  output logic tx_valid_ff,
  output logic [7:0] tx_byte_ff,
  output logic tx_last_ff,
  output logic [15:0] tx_len_ff,
  output logic low_power_ff,
  output logic [7:0] lp_mode_ff,
  output logic radio_standby_ff,
  output logic wake_pulse_ff,
  output logic net_reset_ff,
  output logic [15:0] pan_id_ff,
  output logic [63:0] long_addr_ff,
  output logic [7:0] wake_per_ff,
  output logic [31:0] wake_fall_ff,
  output logic [31:0] wake_rise_ff
);
  import pah_pkg::*;

  // Gray-coded along idle, receive, execute, send; low power is one bit from send, though it is entered from execute.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_EXEC = 3'b011,
    ST_SEND = 3'b010,
    ST_LOW = 3'b110
  } pah_state_type;

  pah_state_type state_ff, nxt_state;
  logic [7:0] op_ff, nxt_op;
  logic [7:0] byte_ff [0:8];
  logic [7:0] nxt_byte [0:8];
  logic [3:0] cnt_ff, nxt_cnt;
  logic ack_en_ff, nxt_ack_en;
  logic [31:0] gpio_out_ff, nxt_gpio_out;
  logic [31:0] nxt_bus_rdata;
  pah_rsp_type nxt_rsp;
  logic nxt_rsp_valid, nxt_tx_valid, nxt_tx_last;
  logic [7:0] nxt_tx_byte;
  logic [15:0] nxt_tx_len;
  logic [3:0] send_k_ff, nxt_send_k, send_b_ff, nxt_send_b;
  logic [7:0] send_a_ff, nxt_send_a;
  logic nxt_low_power, nxt_radio_standby, nxt_wake_pulse, nxt_net_reset;
  logic [7:0] nxt_lp_mode, nxt_wake_per;
  logic [15:0] nxt_pan_id;
  logic [63:0] nxt_long_addr;
  logic [31:0] nxt_wake_fall, nxt_wake_rise;
  logic [31:0] div_ff, nxt_div, secs_ff, nxt_secs;
  logic timer_on_ff, nxt_timer_on;
  logic [31:0] gpio_prev_ff;
  logic wpin_prev_ff;

  // Decoded wakeup masks; a narrow mask leaves pins 24 and up unselectable.
  logic wide_v;
  logic [31:0] fall_v, rise_v, sel_v, bad_v, out_v;
  logic conf_hit;
  logic [4:0] conf_pin;
  assign wide_v = (cnt_ff == LEN_WAKE_WIDE);
  assign fall_v = wide_v ? {byte_ff[1], byte_ff[2], byte_ff[3], byte_ff[4]}
                         : {8'h00, byte_ff[1], byte_ff[2], byte_ff[3]}; // R1 R2
  assign rise_v = wide_v ? {byte_ff[5], byte_ff[6], byte_ff[7], byte_ff[8]}
                         : {8'h00, byte_ff[4], byte_ff[5], byte_ff[6]}; // R1 R2
  assign sel_v = fall_v | rise_v;
  assign bad_v = sel_v & ~GPIO_PINS; // R8
  assign out_v = sel_v & gpio_out_ff; // R9
  logic [63:0] long_v;
  assign long_v = {byte_ff[0], byte_ff[1], byte_ff[2], byte_ff[3], byte_ff[4], byte_ff[5], byte_ff[6], byte_ff[7]};

  // Lowest numbered pin in a mask, so a report is deterministic.
  function automatic logic [4:0] low_pin(input logic [31:0] m);
    logic [4:0] p;
    p = 5'd0;
    for (int i = 31; i >= 0; i--) begin
      if (m[i]) begin
        p = 5'(i);
      end
    end
    return p;
  endfunction : low_pin

  // The lowest-indexed pair that is fully selected is reported.
  always_comb begin
    conf_hit = 1'b0;
    conf_pin = 5'd0;
    for (int i = NPAIR - 1; i >= 0; i--) begin
      if (sel_v[CONFLICT_PAIRS[i*10 +: 5]] && sel_v[CONFLICT_PAIRS[i*10+5 +: 5]]) begin
        conf_hit = 1'b1; // R10
        conf_pin = CONFLICT_PAIRS[i*10+5 +: 5];
      end
    end
  end

  // Wake events, gated by the stored setup and then by the mode.
  logic tick_v, timer_hit, radio_hit, pin_hit, ser_hit, gpio_hit, wake_v;
  assign tick_v = (div_ff == 32'(CYC_PER_SEC - 1));
  assign timer_hit = timer_on_ff && (secs_ff == 32'h0000_0000); // R3 R12
  assign radio_hit = wake_per_ff[PER_RADIO] && wake_src.radio_rx; // R4
  assign pin_hit = wake_per_ff[PER_WAKE_PIN] && wake_src.wake_pin && !wpin_prev_ff; // R5
  assign ser_hit = (wake_per_ff[PER_SER1] && wake_src.ser1) || (wake_per_ff[PER_SER2] && wake_src.ser2)
                   || (wake_per_ff[PER_SPI] && wake_src.spi); // R6
  assign gpio_hit = |((gpio_prev_ff & ~wake_src.gpio & wake_fall_ff) | (~gpio_prev_ff & wake_src.gpio & wake_rise_ff));
  always_comb begin
    if (lp_mode_ff == MODE_STANDBY) begin
      wake_v = timer_hit || pin_hit; // R21 R13
    end else if (lp_mode_ff == MODE_STOP) begin
      wake_v = timer_hit || radio_hit || gpio_hit; // R22 R13
    end else begin
      wake_v = timer_hit || radio_hit || gpio_hit || ser_hit; // R13
    end
  end

  // Next state of frame engine, settings and register port.
  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_byte = byte_ff;
    nxt_cnt = cnt_ff;
    nxt_ack_en = ack_en_ff;
    nxt_gpio_out = gpio_out_ff;
    nxt_bus_rdata = 32'h0000_0000;
    nxt_rsp = rsp_ff;
    nxt_rsp_valid = 1'b0;
    nxt_tx_valid = 1'b0;
    nxt_tx_byte = 8'h00;
    nxt_tx_last = 1'b0;
    nxt_tx_len = tx_len_ff;
    nxt_send_k = send_k_ff;
    nxt_send_a = send_a_ff;
    nxt_send_b = send_b_ff;
    nxt_low_power = low_power_ff;
    nxt_lp_mode = lp_mode_ff;
    nxt_radio_standby = radio_standby_ff;
    nxt_wake_pulse = 1'b0;
    nxt_net_reset = 1'b0;
    nxt_pan_id = pan_id_ff;
    nxt_long_addr = long_addr_ff;
    nxt_wake_per = wake_per_ff;
    nxt_wake_fall = wake_fall_ff;
    nxt_wake_rise = wake_rise_ff;
    nxt_div = 32'h0000_0000;
    nxt_secs = secs_ff;
    nxt_timer_on = timer_on_ff;

    // Register port; the read answer stands for exactly one cycle.
    if (bus_req.wr) begin
      if (bus_req.addr == REG_CTRL) begin
        nxt_ack_en = bus_req.wdata[CTRL_ACK];
      end else if (bus_req.addr == REG_GPIO_OUT) begin
        nxt_gpio_out = bus_req.wdata;
      end
    end
    if (bus_req.rd) begin
      if (bus_req.addr == REG_CTRL) begin
        nxt_bus_rdata = {31'h0000_0000, ack_en_ff};
      end else if (bus_req.addr == REG_GPIO_OUT) begin
        nxt_bus_rdata = gpio_out_ff;
      end else if (bus_req.addr == REG_STATUS) begin
        nxt_bus_rdata = {8'h00, lp_mode_ff, wake_per_ff, 6'h00, radio_standby_ff, low_power_ff};
      end else if (bus_req.addr == REG_WAKE_FALL) begin
        nxt_bus_rdata = wake_fall_ff;
      end else if (bus_req.addr == REG_WAKE_RISE) begin
        nxt_bus_rdata = wake_rise_ff;
      end else if (bus_req.addr == REG_PAN_ID) begin
        nxt_bus_rdata = {16'h0000, pan_id_ff};
      end else if (bus_req.addr == REG_LONG_LO) begin
        nxt_bus_rdata = long_addr_ff[31:0];
      end else if (bus_req.addr == REG_LONG_HI) begin
        nxt_bus_rdata = long_addr_ff[63:32];
      end
    end

    case (state_ff)
      ST_IDLE: begin
        if (frm.start) begin
          nxt_op = frm.op;
          nxt_cnt = 4'h0;
          nxt_state = ST_RX;
        end
      end
      ST_RX: begin
        // Bytes beyond nine are only counted, enough to call the frame long.
        if (frm.valid) begin
          if (cnt_ff <= HDR_LAST) begin
            nxt_byte[cnt_ff] = frm.data;
          end
          if (cnt_ff != LEN_SAT) begin
            nxt_cnt = cnt_ff + 4'h1;
          end
        end
        if (frm.done) begin
          nxt_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        // Every check runs before any store, so a rejected frame leaves settings alone.
        nxt_state = ST_IDLE;
        nxt_rsp = '0;
        nxt_rsp_valid = ack_en_ff; // R7
        case (op_ff)
          OP_WAKE_CFG: begin
            if (cnt_ff < LEN_WAKE_NARROW || cnt_ff == LEN_LONG) begin
              nxt_rsp.code = RSP_SHORT; // R7
            end else if (cnt_ff > LEN_WAKE_WIDE) begin
              nxt_rsp.code = RSP_LONG; // R7
            end else if (|bad_v) begin
              nxt_rsp = '{code: RSP_NOT_GPIO, has_pin: 1'b1, pin: {3'h0, low_pin(bad_v)}}; // R8 R23
            end else if (|out_v) begin
              nxt_rsp = '{code: RSP_IS_OUTPUT, has_pin: 1'b1, pin: {3'h0, low_pin(out_v)}}; // R9 R23
            end else if (conf_hit) begin
              nxt_rsp = '{code: RSP_CONFLICT, has_pin: 1'b1, pin: {3'h0, conf_pin}}; // R10 R23
            end else begin
              nxt_wake_per = byte_ff[0] & PER_USED; // R3
              nxt_wake_fall = fall_v; // R1
              nxt_wake_rise = rise_v; // R1
            end
          end
          OP_POWER_DOWN: begin
            if (cnt_ff < LEN_POWER) begin
              nxt_rsp.code = RSP_SHORT; // R7
            end else if (cnt_ff > LEN_POWER) begin
              nxt_rsp.code = RSP_LONG; // R7
            end else if (byte_ff[0] != MODE_SLEEP && byte_ff[0] != MODE_STOP && byte_ff[0] != MODE_STANDBY) begin
              nxt_rsp.code = RSP_BAD_VALUE; // R11
            end else begin
              nxt_state = ST_LOW;
              nxt_low_power = 1'b1;
              nxt_lp_mode = byte_ff[0]; // R11
              nxt_radio_standby = !wake_per_ff[PER_RADIO] || (byte_ff[0] == MODE_STANDBY); // R4
              nxt_timer_on = wake_per_ff[PER_TIMER]; // R12
              nxt_secs = {byte_ff[1], byte_ff[2], byte_ff[3], byte_ff[4]}; // R12
            end
          end
          OP_GET_ADDR: begin
            // Extras are ignored; the data goes out, acknowledges or not.
            nxt_rsp_valid = 1'b0; // R14
            nxt_tx_len = 16'(HDR_LEN + NET_BYTES * NADDR); // R14
            nxt_send_k = 4'h0;
            nxt_send_a = 8'h00;
            nxt_send_b = 4'h0;
            nxt_state = ST_SEND;
          end
          OP_SET_LONG: begin
            if (cnt_ff < LEN_LONG) begin
              nxt_rsp.code = RSP_SHORT; // R7
            end else if (cnt_ff > LEN_LONG_RST) begin
              nxt_rsp.code = RSP_LONG; // R7
            end else if (long_v == 64'h0000_0000_0000_0000 || long_v == 64'hFFFF_FFFF_FFFF_FFFF) begin
              nxt_rsp.code = RSP_BAD_ADDR; // R17
            end else begin
              nxt_long_addr = long_v; // R16
              nxt_net_reset = (cnt_ff == LEN_LONG_RST) && (byte_ff[8] != 8'h00); // R16
            end
          end
          OP_SET_ID: begin
            if (cnt_ff < LEN_ID) begin
              nxt_rsp.code = RSP_SHORT; // R7
            end else if (cnt_ff > LEN_ID) begin
              nxt_rsp.code = RSP_LONG; // R7
            end else if ({byte_ff[0], byte_ff[1]} == ID_INVALID) begin
              nxt_rsp.code = RSP_BAD_VALUE; // R19
            end else begin
              // Takes effect at once; queued frames pick it up too.
              nxt_pan_id = {byte_ff[0], byte_ff[1]}; // R18 R20
            end
          end
          default: begin
            nxt_rsp_valid = 1'b0;
          end
        endcase
        // Errors always answer, whatever the acknowledge setting.
        if (nxt_rsp.code != RSP_OK) begin
          nxt_rsp_valid = 1'b1; // R7
        end
      end
      ST_SEND: begin
        // One byte a cycle: code, identifier MSB first, then each address MSB first.
        nxt_tx_valid = 1'b1;
        if (send_k_ff == 4'h0) begin
          nxt_tx_byte = RSP_OK;
          nxt_send_k = 4'h1;
        end else if (send_k_ff <= HDR_LAST) begin
          nxt_tx_byte = long_addr_ff[8 * (8 - int'(send_k_ff)) +: 8]; // R15
          nxt_send_k = send_k_ff + 4'h1;
        end else begin
          nxt_tx_byte = net_addr[send_a_ff][8 * (15 - int'(send_b_ff)) +: 8]; // R15
          if (send_b_ff == NET_LAST) begin
            nxt_send_b = 4'h0;
            nxt_send_a = send_a_ff + 8'h01;
            if (send_a_ff == 8'(NADDR - 1)) begin
              nxt_tx_last = 1'b1;
              nxt_state = ST_IDLE;
            end
          end else begin
            nxt_send_b = send_b_ff + 4'h1;
          end
        end
      end
      ST_LOW: begin
        // Frames are ignored while asleep; seconds only count with the timer on.
        if (timer_on_ff && secs_ff != 32'h0000_0000) begin
          nxt_div = tick_v ? 32'h0000_0000 : div_ff + 32'h0000_0001;
          if (tick_v) begin
            nxt_secs = secs_ff - 32'h0000_0001; // R12
          end
        end
        if (wake_v) begin
          nxt_state = ST_IDLE; // R13
          nxt_low_power = 1'b0;
          nxt_radio_standby = 1'b0;
          nxt_timer_on = 1'b0;
          nxt_wake_pulse = 1'b1;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Register stage for everything above.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
      op_ff <= 8'h00;
      for (int i = 0; i <= 8; i++) begin
        byte_ff[i] <= 8'h00;
      end
      cnt_ff <= 4'h0;
      ack_en_ff <= RST_ACK;
      gpio_out_ff <= 32'h0000_0000;
      bus_rdata_ff <= 32'h0000_0000;
      rsp_ff <= '0;
      rsp_valid_ff <= 1'b0;
      tx_valid_ff <= 1'b0;
      tx_byte_ff <= 8'h00;
      tx_last_ff <= 1'b0;
      tx_len_ff <= 16'h0000;
      send_k_ff <= 4'h0;
      send_a_ff <= 8'h00;
      send_b_ff <= 4'h0;
      low_power_ff <= 1'b0;
      lp_mode_ff <= MODE_SLEEP;
      radio_standby_ff <= 1'b0;
      wake_pulse_ff <= 1'b0;
      net_reset_ff <= 1'b0;
      pan_id_ff <= RST_PAN_ID;
      long_addr_ff <= RST_LONG_ADDR;
      wake_per_ff <= 8'h00;
      wake_fall_ff <= 32'h0000_0000;
      wake_rise_ff <= 32'h0000_0000;
      div_ff <= 32'h0000_0000;
      secs_ff <= 32'h0000_0000;
      timer_on_ff <= 1'b0;
      gpio_prev_ff <= 32'h0000_0000;
      wpin_prev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      byte_ff <= nxt_byte;
      cnt_ff <= nxt_cnt;
      ack_en_ff <= nxt_ack_en;
      gpio_out_ff <= nxt_gpio_out;
      bus_rdata_ff <= nxt_bus_rdata;
      rsp_ff <= nxt_rsp;
      rsp_valid_ff <= nxt_rsp_valid;
      tx_valid_ff <= nxt_tx_valid;
      tx_byte_ff <= nxt_tx_byte;
      tx_last_ff <= nxt_tx_last;
      tx_len_ff <= nxt_tx_len;
      send_k_ff <= nxt_send_k;
      send_a_ff <= nxt_send_a;
      send_b_ff <= nxt_send_b;
      low_power_ff <= nxt_low_power;
      lp_mode_ff <= nxt_lp_mode;
      radio_standby_ff <= nxt_radio_standby;
      wake_pulse_ff <= nxt_wake_pulse;
      net_reset_ff <= nxt_net_reset;
      pan_id_ff <= nxt_pan_id;
      long_addr_ff <= nxt_long_addr;
      wake_per_ff <= nxt_wake_per;
      wake_fall_ff <= nxt_wake_fall;
      wake_rise_ff <= nxt_wake_rise;
      div_ff <= nxt_div;
      secs_ff <= nxt_secs;
      timer_on_ff <= nxt_timer_on;
      gpio_prev_ff <= wake_src.gpio;
      wpin_prev_ff <= wake_src.wake_pin;
    end
  end

endmodule : pah_cmd_handler

/* File: verilog/pah_pkg.sv */
// Constants and carrier types of the power and address command handler.
package pah_pkg;

  // Clock rate and the one-second tick of the low-power timer.
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned CYC_PER_SEC = CLK_HZ * TICK_S;

  // Command opcodes; the values are arbitrary.
  typedef enum logic [7:0] {
    OP_WAKE_CFG = 8'h05,
    OP_POWER_DOWN = 8'h06,
    OP_GET_ADDR = 8'h07,
    OP_SET_LONG = 8'h08,
    OP_SET_ID = 8'h09
  } pah_op_type;

  // Response codes.
  localparam logic [7:0] RSP_OK = 8'h00;
  localparam logic [7:0] RSP_SHORT = 8'h01;
  localparam logic [7:0] RSP_LONG = 8'h02;
  localparam logic [7:0] RSP_BAD_VALUE = 8'h03;
  localparam logic [7:0] RSP_NOT_GPIO = 8'h08;
  localparam logic [7:0] RSP_IS_OUTPUT = 8'h09;
  localparam logic [7:0] RSP_CONFLICT = 8'h0C;
  localparam logic [7:0] RSP_BAD_ADDR = 8'h13;

  // Peripheral source mask bit positions.
  localparam int unsigned PER_TIMER = 0;
  localparam int unsigned PER_RADIO = 1;
  localparam int unsigned PER_WAKE_PIN = 2;
  localparam int unsigned PER_SER1 = 3;
  localparam int unsigned PER_SER2 = 4;
  localparam int unsigned PER_SPI = 5;
  localparam logic [7:0] PER_USED = 8'h3F;

  // Low-power mode values.
  localparam logic [7:0] MODE_SLEEP = 8'h00;
  localparam logic [7:0] MODE_STOP = 8'h02;
  localparam logic [7:0] MODE_STANDBY = 8'h04;

  // Frame field lengths in bytes.
  localparam logic [3:0] LEN_WAKE_NARROW = 4'h7;
  localparam logic [3:0] LEN_WAKE_WIDE = 4'h9;
  localparam logic [3:0] LEN_POWER = 4'h5;
  localparam logic [3:0] LEN_LONG = 4'h8;
  localparam logic [3:0] LEN_LONG_RST = 4'h9;
  localparam logic [3:0] LEN_ID = 4'h2;
  localparam logic [3:0] LEN_SAT = 4'hA;
  localparam logic [3:0] HDR_LAST = 4'h8;
  localparam logic [3:0] NET_LAST = 4'hF;
  localparam int unsigned HDR_LEN = 9;
  localparam int unsigned NET_BYTES = 16;
  localparam logic [15:0] ID_INVALID = 16'hFFFF;

  // Pins that are GPIOs, and pin pairs that cannot both wake the device.
  localparam logic [31:0] GPIO_PINS_DEF = 32'h01FB_32FE;
  localparam logic [39:0] CONFLICT_DEF = {5'd20, 5'd9, 5'd19, 5'd5, 5'd24, 5'd2, 5'd23, 5'd1};

  // Register port map and fields.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_GPIO_OUT = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_WAKE_FALL = 4'h3;
  localparam logic [3:0] REG_WAKE_RISE = 4'h4;
  localparam logic [3:0] REG_PAN_ID = 4'h5;
  localparam logic [3:0] REG_LONG_LO = 4'h6;
  localparam logic [3:0] REG_LONG_HI = 4'h7;
  localparam int unsigned CTRL_ACK = 0;

  // Reset values.
  localparam logic RST_ACK = 1'b1;
  localparam logic [15:0] RST_PAN_ID = 16'h0000;
  localparam logic [63:0] RST_LONG_ADDR = 64'h0000_0000_0000_0001;

  // Carrier types.
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pah_bus_req_type;

  typedef struct packed {
    logic start;
    logic [7:0] op;
    logic valid;
    logic [7:0] data;
    logic done;
  } pah_frame_type;

  typedef struct packed {
    logic [7:0] code;
    logic has_pin;
    logic [7:0] pin;
  } pah_rsp_type;

  typedef struct packed {
    logic radio_rx;
    logic wake_pin;
    logic ser1;
    logic ser2;
    logic spi;
    logic [31:0] gpio;
  } pah_wake_src_type;

endpackage : pah_pkg
